// [common/kbilat_pkg.sv]
// Constants shared by the keypad interrupt latch and its helpers.
// Assumes a 32-bit APB register bus and eight port pins.
package kbilat_pkg;

	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int PINS   = 8;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int VEC_W  = 16;

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] STATUS_CONTROL_OFF = 8'h00;
	localparam logic [ADDR_W-1:0] PIN_ENABLE_OFF     = 8'h04;
	localparam logic [ADDR_W-1:0] BREAK_CONTROL_OFF  = 8'h08;

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int MODE_BIT = 0;
	localparam int MASK_BIT = 1;
	localparam int ACK_BIT  = 2;
	localparam int FLAG_BIT = 3;
	localparam int BREAK_CLEAR_ENABLE_BIT = 0;

	localparam logic [PINS-1:0] ENABLE_RST = 8'h00;
	localparam logic            MODE_RST   = 1'b0;
	localparam logic            MASK_RST   = 1'b0;
	localparam logic            BREAK_CLEAR_ENABLE_RST   = 1'b0;

	// Handler address pair fetched by the processor
	localparam logic [VEC_W-1:0] VECTOR_HI_ADDR = 16'hFFE0;
	localparam logic [VEC_W-1:0] VECTOR_LO_ADDR = 16'hFFE1;

endpackage

// [common/kbilat_pin_if.sv]
// Pin path signals between the latch core and its helper modules.
// Assumes all members except pin_raw live on the single bus clock.
`timescale 1ns/1ps
interface kbilat_pin_if;
	import kbilat_pkg::*;

	logic [PINS-1:0] pin_raw;
	logic [PINS-1:0] pin_sync;
	logic [PINS-1:0] enable;
	logic            any_low;
	logic            fall;

	modport sync_side (input pin_raw, output pin_sync);
	modport detect_side (input pin_sync, input enable, output any_low, output fall);
	modport core_side (output pin_raw, output enable, input pin_sync, input any_low, input fall);
endinterface // kbilat_pin_if

// [rtl/kbilat_sync.sv]
// Two-stage synchroniser for the raw keypad pin levels.
// Assumes pins are asynchronous to clock.
`timescale 1ns/1ps
module kbilat_sync (
	input wire logic           clock,
	input wire logic           rst,
	kbilat_pin_if.sync_side    pins
);
	import kbilat_pkg::*;

	logic [PINS-1:0] meta_q;
	logic [PINS-1:0] sync_q;

	// Idle pins read high, so both stages reset to ones
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			meta_q <= '1;
			sync_q <= '1;
		end else begin
			meta_q <= pins.pin_raw;
			sync_q <= meta_q;
		end
	end

	assign pins.pin_sync = sync_q;
endmodule // kbilat_sync

// [rtl/kbilat_detect.sv]
// Detects the all-high to any-low transition of the enabled pins.
// Assumes synchronised pin levels on the same clock.
`timescale 1ns/1ps
module kbilat_detect (
	input wire logic           clock,
	input wire logic           rst,
	kbilat_pin_if.detect_side  pins
);
	import kbilat_pkg::*;

	logic            all_high_q;
	logic [PINS-1:0] low_enabled;

	// Disabled pins are forced out of the OR
	assign low_enabled = pins.enable & ~pins.pin_sync;
	assign pins.any_low = |low_enabled;
	assign pins.fall    = pins.any_low & all_high_q;

	// Remember whether every enabled pin was high last cycle
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			all_high_q <= 1'b1;
		end else begin
			all_high_q <= ~pins.any_low;
		end
	end
endmodule // kbilat_detect

// [rtl/kbilat_top.sv]
// Keypad interrupt latch: eight port pins, one request to the processor.
// Assumes an APB master on clock, pins asynchronous, and a port block
// that owns the data and direction registers of the pins.
//
// Notes on behaviour
// - eight keypad inputs on the port pins, each with its own enable.
// - a pin whose enable is clear never contributes to a request.
// - setting an enable bit also turns on that pin's pullup.
// - request latches when enabled pins go from all high to any low.
// - edge mode: a fall is ignored while another enabled pin is low.
// - level mode: request holds while any enabled pin stays low.
// - level mode: clears after acknowledge and all pins high, any order.
// - edge mode: vector fetch or software acknowledge clears at once.
// - writing one to acknowledge clears; it reads zero and resets clear.
// - acknowledge does not block later falls; a new fall relatches.
// - unmasked request makes the processor fetch the handler pair.
// - reset clears the latch and the mode bit even if a pin is low.
// - pending flag shows the latch regardless of mask; reset clears it.
// - mask bit is read/write, reset clear; one blocks the request.
// - mode bit is read/write, reset clear; one adds level sensing.
// - upper four bits of status and control always read zero.
// - enabled pin is forced to input; pin level readable if direction zero.
// - reset clears every pin enable bit.
// - logic runs in wait and stop; unmasked request wakes the core.
// - in break, acknowledge clears only with break clear enable set (software writes only; a vector fetch always clears).
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
module kbilat_top (
	input  wire logic                              clock,
	input  wire logic                              rst,
	// APB slave
	input  wire logic                              psel,
	input  wire logic                              penable,
	input  wire logic                              pwrite,
	input  wire logic [kbilat_pkg::ADDR_W-1:0]     paddr,
	input  wire logic [kbilat_pkg::DATA_W-1:0]     pwdata,
	output logic      [kbilat_pkg::DATA_W-1:0]     prdata,
	output logic                                   pready,
	output logic                                   pslverr,
	// Port pins and the port block
	input  wire logic [kbilat_pkg::PINS-1:0]       port_a_pin_i,
	input  wire logic [kbilat_pkg::PINS-1:0]       port_a_direction,
	input  wire logic [kbilat_pkg::PINS-1:0]       port_a_data,
	output logic      [kbilat_pkg::PINS-1:0]       port_a_pin_o,
	output logic      [kbilat_pkg::PINS-1:0]       port_a_pin_oe,
	output logic      [kbilat_pkg::PINS-1:0]       port_a_pullup_en,
	output logic      [kbilat_pkg::PINS-1:0]       port_a_level,
	// Processor side
	input  wire logic                              vector_fetch_valid,
	input  wire logic [kbilat_pkg::VEC_W-1:0]      vector_fetch_addr,
	input  wire logic                              break_active,
	output logic                                   irq_request,
	output logic                                   wake_request,
	output logic      [kbilat_pkg::VEC_W-1:0]      irq_vector_addr
);
	import kbilat_pkg::*;

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	kbilat_pin_if pins ();

	logic [PINS-1:0]   pin_source_enable_q;
	logic              request_mask_q;
	logic              trigger_sensitivity_select_q;
	logic              break_clear_enable_q;
	logic              latch_q;
	logic              latch_d;
	logic              ack_seen_q;
	logic              ack_seen_d;
	logic [DATA_W-1:0] prdata_q;
	logic              pslverr_q;
	logic [PINS-1:0]   pin_o_q;
	logic [VEC_W-1:0]  vector_q;

	// Next values of the registers above
	logic [PINS-1:0]   pin_source_enable_d;
	logic              request_mask_d;
	logic              trigger_sensitivity_select_d;
	logic              break_clear_enable_d;
	logic [DATA_W-1:0] prdata_d;
	logic              pslverr_d;
	logic [PINS-1:0]   pin_o_d;
	logic [VEC_W-1:0]  vector_d;

	wire               setup_phase;
	wire               access_phase;
	wire               wr_access;
	wire               hit_status;
	wire               hit_enable;
	wire               hit_break;
	wire               hit_any;
	wire               wr_status;
	wire               wr_enable;
	wire               wr_break;
	wire               sw_ack_write;
	wire               sw_ack;
	wire               fetch_ack;
	wire               ack;
	wire               level_mode;
	wire               all_high;
	wire               ack_pending;
	wire               clear_edge;
	wire               clear_level;
	wire               clear_now;
	wire               request_unmasked;
	wire [DATA_W-1:0]  rd_status;
	wire [DATA_W-1:0]  rd_enable;
	wire [DATA_W-1:0]  rd_break;
	wire [DATA_W-1:0]  rd_word;

	// ------------------------------------------------------------
	// Pin synchroniser and transition detector
	// ------------------------------------------------------------
	assign pins.pin_raw = port_a_pin_i;
	assign pins.enable  = pin_source_enable_q;

	// Pins cross into clock through two flops before anything looks
	kbilat_sync u_sync (
		.clock (clock),
		.rst   (rst),
		.pins  (pins.sync_side)
	);

	// Falls are seen only against an all-high history of enabled pins
	kbilat_detect u_detect (
		.clock (clock),
		.rst   (rst),
		.pins  (pins.detect_side)
	);

	// Everything below sees the pins two edges late; software must allow
	// for that delay after it changes an enable bit
	assign all_high = ~pins.any_low;

	// ------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------
	// Zero wait states: data is captured in setup, so ready is constant
	assign setup_phase  = psel & ~penable;
	assign access_phase = psel & penable;
	assign wr_access    = access_phase & pwrite;

	// Unmapped offsets answer with an error and read as zero; a write to
	// one of them changes nothing
	assign hit_status = (paddr == STATUS_CONTROL_OFF);
	assign hit_enable = (paddr == PIN_ENABLE_OFF);
	assign hit_break  = (paddr == BREAK_CONTROL_OFF);
	assign hit_any    = hit_status | hit_enable | hit_break;

	assign wr_status = wr_access & hit_status;
	assign wr_enable = wr_access & hit_enable;
	assign wr_break  = wr_access & hit_break;

	// ------------------------------------------------------------
	// Read data assembly
	// ------------------------------------------------------------
	// Acknowledge is write-only and the top nibble is unused
	assign rd_status[MODE_BIT]             = trigger_sensitivity_select_q;
	assign rd_status[MASK_BIT]             = request_mask_q;
	assign rd_status[ACK_BIT]              = 1'b0;
	assign rd_status[FLAG_BIT]             = latch_q;
	assign rd_status[DATA_W-1:FLAG_BIT+1]  = '0;

	assign rd_enable[PINS-1:0]             = pin_source_enable_q;
	assign rd_enable[DATA_W-1:PINS]        = '0;

	assign rd_break[BREAK_CLEAR_ENABLE_BIT]              = break_clear_enable_q;
	assign rd_break[DATA_W-1:BREAK_CLEAR_ENABLE_BIT+1]   = '0;

	assign rd_word = hit_status ? rd_status :
	                 hit_enable ? rd_enable :
	                 hit_break  ? rd_break  : '0;

	// Read data and error are captured at the setup edge, so they stand
	// through the access phase even if a register moves meanwhile
	assign prdata_d  = !setup_phase ? prdata_q :
	                   pwrite       ? '0       : rd_word;
	assign pslverr_d = setup_phase ? ~hit_any : pslverr_q;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			prdata_q  <= '0;
			pslverr_q <= 1'b0;
		end else begin
			prdata_q  <= prdata_d;
			pslverr_q <= pslverr_d;
		end
	end

	assign prdata  = prdata_q;
	assign pready  = 1'b1;
	assign pslverr = pslverr_q;

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	// Mask and mode live in the status and control word
	assign request_mask_d               = wr_status ? pwdata[MASK_BIT] :
	                                      request_mask_q;
	assign trigger_sensitivity_select_d = wr_status ? pwdata[MODE_BIT] :
	                                      trigger_sensitivity_select_q;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			request_mask_q               <= MASK_RST;
			trigger_sensitivity_select_q <= MODE_RST;
		end else begin
			request_mask_q               <= request_mask_d;
			trigger_sensitivity_select_q <= trigger_sensitivity_select_d;
		end
	end

	// One enable per pin; reset leaves every pin out of the keypad
	assign pin_source_enable_d = wr_enable ? pwdata[PINS-1:0] :
	                             pin_source_enable_q;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pin_source_enable_q <= ENABLE_RST;
		end else begin
			pin_source_enable_q <= pin_source_enable_d;
		end
	end

	// Break clear enable defaults to protecting the latch
	assign break_clear_enable_d = wr_break ? pwdata[BREAK_CLEAR_ENABLE_BIT] :
	                              break_clear_enable_q;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			break_clear_enable_q <= BREAK_CLEAR_ENABLE_RST;
		end else begin
			break_clear_enable_q <= break_clear_enable_d;
		end
	end

	// ------------------------------------------------------------
	// Acknowledge sources
	// ------------------------------------------------------------
	// The acknowledge bit is never stored, only pulsed by the write
	assign sw_ack_write = wr_status & pwdata[ACK_BIT];

	// In break the write is dropped unless clearing is allowed
	assign sw_ack = sw_ack_write &
	                (~break_active | break_clear_enable_q);

	// Only the first byte of the pair counts, so one fetch is one ack
	assign fetch_ack = vector_fetch_valid &
	                   (vector_fetch_addr == VECTOR_HI_ADDR);

	assign ack = sw_ack | fetch_ack;

	// ------------------------------------------------------------
	// Request latch
	// ------------------------------------------------------------
	assign level_mode = trigger_sensitivity_select_q;

	// Edge mode drops the request on any acknowledge
	assign clear_edge = ack;

	// Level mode needs an acknowledge, now or earlier, and all pins high
	assign ack_pending = ack | ack_seen_q;
	assign clear_level = ack_pending & all_high;

	// Mode comes from the register, so a write that changes it only
	// steers the clear decisions that follow that write
	assign clear_now = level_mode ? clear_level : clear_edge;

	// A fall in the same cycle as a clear wins, so no press is lost.
	// Limitation: turning on level mode while a pin is already low raises
	// nothing; only a fresh fall from the all-high state sets the latch
	assign latch_d = pins.fall | (latch_q & ~clear_now);

	// Level mode remembers an acknowledge that came while pins were low
	assign ack_seen_d = level_mode & latch_d & ~pins.fall &
	                    ack_pending;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			latch_q    <= 1'b0;
			ack_seen_q <= 1'b0;
		end else begin
			latch_q    <= latch_d;
			ack_seen_q <= ack_seen_d;
		end
	end

	// ------------------------------------------------------------
	// Processor request and wake-up
	// ------------------------------------------------------------
	// The mask hides the request but never the pending flag
	assign request_unmasked = latch_q & ~request_mask_q;

	// No clock gating here: the block keeps running in wait and stop
	assign irq_request  = request_unmasked;
	assign wake_request = request_unmasked;

	// Handler address offered while the request is up. It looks at the
	// next latch and mask values, so it rises and falls on the same edge
	// as the request that it belongs to
	assign vector_d = (latch_d & ~request_mask_d) ? VECTOR_HI_ADDR : '0;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			vector_q <= '0;
		end else begin
			vector_q <= vector_d;
		end
	end

	assign irq_vector_addr = vector_q;

	// ------------------------------------------------------------
	// Pad control per pin
	// ------------------------------------------------------------
	// Output data follows the port block, one cycle late; the extra flop
	// keeps the pad driven from a register rather than from port logic
	assign pin_o_d = port_a_data;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pin_o_q <= '0;
		end else begin
			pin_o_q <= pin_o_d;
		end
	end

	// Enabling a pin overrides its direction and turns on its pullup.
	// The output enable drops in the same cycle as the enable bit rises,
	// so the pad never fights a key that is already pressed
	for (genvar i = 0; i < PINS; i++) begin : g_pad
		assign port_a_pin_o[i]     = pin_o_q[i];
		assign port_a_pin_oe[i]    = port_a_direction[i] &
		                             ~pin_source_enable_q[i];
		assign port_a_pullup_en[i] = pin_source_enable_q[i];
		// Synchronised level for the port read path; the port block
		// only shows it when its direction bit is zero
		assign port_a_level[i]     = pins.pin_sync[i];
	end

endmodule // kbilat_top

// [test/kbilat_monitor.sv]
// Checker on the keypad latch top ports.
// Assumes one bus clock and an asynchronous active-high reset.
`timescale 1ns/1ps
module kbilat_monitor (
	input wire logic                         clock,
	input wire logic                         rst,
	input wire logic                         psel,
	input wire logic                         penable,
	input wire logic                         pwrite,
	input wire logic [kbilat_pkg::ADDR_W-1:0] paddr,
	input wire logic [kbilat_pkg::DATA_W-1:0] prdata,
	input wire logic [kbilat_pkg::PINS-1:0]   port_a_pin_oe,
	input wire logic [kbilat_pkg::PINS-1:0]   port_a_pullup_en,
	input wire logic                         irq_request,
	input wire logic                         wake_request,
	input wire logic [kbilat_pkg::VEC_W-1:0]  irq_vector_addr
);
	import kbilat_pkg::*;
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	a_pullup_on_write: assert property ($changed(port_a_pullup_en) |->
		$past(psel && penable && pwrite && paddr == PIN_ENABLE_OFF))
		else $error("pullup moved without enable write");
	a_enabled_is_input: assert property ((port_a_pin_oe & port_a_pullup_en) == 8'h00)
		else $error("enabled pin still driven");
	a_wake_matches: assert property (wake_request == irq_request)
		else $error("wake differs from request");
	a_vector_tracks: assert property (irq_vector_addr ==
		(irq_request ? VECTOR_HI_ADDR : 16'h0000))
		else $error("vector address wrong");
	a_source_needed: assert property ($rose(irq_request) |-> $past(port_a_pullup_en) != 8'h00)
		else $error("request with no pin enabled");
	a_reset_clears_req: assert property ($fell(rst) |-> !irq_request)
		else $error("request survived reset");
	a_reset_clears_en: assert property ($fell(rst) |-> port_a_pullup_en == 8'h00)
		else $error("enables survived reset");
	a_status_zero_bits: assert property (psel && penable && !pwrite &&
		paddr == STATUS_CONTROL_OFF |-> prdata[ACK_BIT] == 1'b0 && prdata[7:4] == 4'h0)
		else $error("status reads nonzero in fixed bits");
endmodule // kbilat_monitor

bind kbilat_top kbilat_monitor mon_u (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .port_a_pin_oe(port_a_pin_oe),
	.port_a_pullup_en(port_a_pullup_en), .irq_request(irq_request),
	.wake_request(wake_request), .irq_vector_addr(irq_vector_addr));

// [test/kbilat_keypad.sv]
// Keypad switches on the port pins: a pressed key shorts its pin low.
// Assumes pullup and drive controls come from the latch top.
`timescale 1ns/1ps
module kbilat_keypad (
	input  wire logic                         clock,
	input  wire logic [kbilat_pkg::PINS-1:0]  pressed,
	input  wire logic [kbilat_pkg::PINS-1:0]  pullup_en,
	input  wire logic [kbilat_pkg::PINS-1:0]  pin_o,
	input  wire logic [kbilat_pkg::PINS-1:0]  pin_oe,
	output logic      [kbilat_pkg::PINS-1:0]  pin
);
	import kbilat_pkg::*;
	logic [PINS-1:0] float_q = 8'hAA;
	// Undriven pins without pullup wander, so stale levels never look valid
	always @(posedge clock) begin
		float_q <= ~float_q;
	end
	// Driver wins, then a key to ground, then the pullup
	assign pin = (pin_oe & pin_o) | (~pin_oe & ~pressed & (pullup_en | float_q));
endmodule // kbilat_keypad

// [test/tb_kbilat_top.sv]
// Self-checking bench for the keypad latch with an APB master.
// Assumes the keypad partner model and the bound checker.
`timescale 1ns/1ps
module tb_kbilat_top;
	import kbilat_pkg::*;
	typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] q; logic e;} kbilat_row_t;
	logic              clock = 1'b0;
	logic              rst = 1'b1;
	logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
	logic [ADDR_W-1:0] paddr = 8'h00;
	logic [DATA_W-1:0] pwdata = 32'h0000_0000, prdata, rd;
	logic [PINS-1:0]   keys = 8'h00, dir = 8'h00, pdata = 8'hFF;
	logic [PINS-1:0]   pin, pin_o, pin_oe, pull, lvl;
	logic              vf_v = 1'b0, brk = 1'b0, irq, wake;
	logic [VEC_W-1:0]  vf_a = 16'h0000, vec;
	int                failures = 0, samples_checked = 0, cyc = 0;
	kbilat_row_t       rows[5] = '{'{PIN_ENABLE_OFF, 8'hA5, 8'hA5, 1'b0},
		'{PIN_ENABLE_OFF, 8'h00, 8'h00, 1'b0}, '{8'h0C, 8'h55, 8'h00, 1'b1},
		'{STATUS_CONTROL_OFF, 8'hFF, 8'h03, 1'b0}, '{STATUS_CONTROL_OFF, 8'h00, 8'h00, 1'b0}};

	always #12.5 clock = ~clock;

	kbilat_top dut_u (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.port_a_pin_i(pin), .port_a_direction(dir), .port_a_data(pdata), .port_a_pin_o(pin_o),
		.port_a_pin_oe(pin_oe), .port_a_pullup_en(pull), .port_a_level(lvl),
		.vector_fetch_valid(vf_v), .vector_fetch_addr(vf_a), .break_active(brk),
		.irq_request(irq), .wake_request(wake), .irq_vector_addr(vec));
	kbilat_keypad key_u (.clock(clock), .pressed(keys), .pullup_en(pull), .pin_o(pin_o),
		.pin_oe(pin_oe), .pin(pin));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One APB transfer; waits on pready, settles before returning
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask
	// Key edges reach the request three edges later, so five is ample
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic give_verdict;
		$display("Checks %0d, mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Hang guard, far above the length of the sequence
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			failures++;
			give_verdict();
		end
	end

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		apb(0, STATUS_CONTROL_OFF, 0); chk(rd, 0);
		apb(0, PIN_ENABLE_OFF, 0); chk(rd, 0);
		foreach (rows[i]) begin
			apb(1, rows[i].a, rows[i].d);
			apb(0, rows[i].a, 0); chk(rd, rows[i].q);
			chk(er, rows[i].e);
		end
		$display("register table done");
		apb(1, STATUS_CONTROL_OFF, 8'h02);
		apb(1, PIN_ENABLE_OFF, 8'h0F); chk(pull, 8'h0F);
		apb(1, STATUS_CONTROL_OFF, 8'h06);
		apb(1, STATUS_CONTROL_OFF, 8'h00); chk(irq, 0);
		keys <= 8'h01; tick(5); chk(irq, 1);
		chk(vec, VECTOR_HI_ADDR);
		chk(wake, 1);
		apb(0, STATUS_CONTROL_OFF, 0); chk(rd, 8'h08);
		apb(1, STATUS_CONTROL_OFF, 8'h04); chk(irq, 0);
		keys <= 8'h03; tick(5); chk(irq, 0);
		keys <= 8'h00; tick(5);
		keys <= 8'h04; tick(5); chk(irq, 1);
		@(posedge clock);
		vf_v <= 1'b1;
		vf_a <= VECTOR_HI_ADDR;
		@(posedge clock);
		vf_v <= 1'b0;
		#1 chk(irq, 0);
		keys <= 8'h80; tick(5); chk(irq, 0);
		keys <= 8'h00; tick(3);
		$display("edge mode done");
		apb(1, STATUS_CONTROL_OFF, 8'h02);
		keys <= 8'h02; tick(5); chk(irq, 0);
		apb(0, STATUS_CONTROL_OFF, 0); chk(rd, 8'h0A);
		apb(1, STATUS_CONTROL_OFF, 8'h00); tick(2); chk(irq, 1);
		apb(1, STATUS_CONTROL_OFF, 8'h04);
		keys <= 8'h00; tick(3);
		$display("mask done");
		apb(1, STATUS_CONTROL_OFF, 8'h01);
		keys <= 8'h08; tick(5); chk(irq, 1);
		apb(1, STATUS_CONTROL_OFF, 8'h05); tick(2); chk(irq, 1);
		keys <= 8'h00; tick(5); chk(irq, 0);
		keys <= 8'h08; tick(5);
		keys <= 8'h00; tick(5); chk(irq, 1);
		apb(1, STATUS_CONTROL_OFF, 8'h05); chk(irq, 0);
		$display("level mode done");
		@(posedge clock);
		brk <= 1'b1;
		keys <= 8'h04; tick(5);
		keys <= 8'h00; tick(5);
		apb(1, STATUS_CONTROL_OFF, 8'h05); chk(irq, 1);
		apb(1, BREAK_CONTROL_OFF, 8'h01);
		apb(1, STATUS_CONTROL_OFF, 8'h05); chk(irq, 0);
		@(posedge clock);
		brk <= 1'b0; tick(2); chk(irq, 0);
		apb(1, BREAK_CONTROL_OFF, 8'h00);
		$display("break done");
		keys <= 8'h01; tick(5); chk(irq, 1);
		@(posedge clock);
		rst <= 1'b1; tick(2);
		@(posedge clock);
		rst <= 1'b0; tick(2); chk(irq, 0);
		apb(0, STATUS_CONTROL_OFF, 0); chk(rd, 0);
		keys <= 8'h00;
		$display("reset done");
		@(posedge clock);
		dir <= 8'hFF;
		apb(1, PIN_ENABLE_OFF, 8'h0F); tick(3); chk(pin_oe, 8'hF0);
		chk(lvl, 8'hFF);
		chk(pin_o, 8'hFF);
		$display("direction done");
		give_verdict();
	end
endmodule // tb_kbilat_top
